// File: src/sac_clkdiv.sv
// Converter clock divider: a one-cycle enable pulse every 4*(1+div) cycles.
// Assumes div_i is held stable while run_i is high.
`timescale 1ns/10ps

module sac_clkdiv
  import sac_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [7:0] div_i,
  output logic            tick_o
);
  logic [9:0] count;
  logic [9:0] last;

  assign last = 10'(DIV_MULT * (int'(div_i) + 1) - 1);

  // The converter clock exists only as this enable and never leaves the block.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i)
    begin
      count  <= 10'h000;
      tick_o <= 1'b0;
    end
    else if (count == last)
    begin
      count  <= 10'h000;
      tick_o <= 1'b1;
    end
    else
    begin
      count  <= count + 10'h001;
      tick_o <= 1'b0;
    end
  end
endmodule

// File: src/sac_conv_if.sv
// Signals between the sequencer and the successive-approximation register.
// Assumes both ends run on the one system clock.
`timescale 1ns/10ps

interface sac_conv_if;
  import sac_pkg::*;
  logic             tick;
  logic             start;
  logic [3:0]       stop_idx;
  logic             comp;
  logic [RES_W-1:0] trial;
  logic [RES_W-1:0] result;
  logic             busy;
  logic             done;
  modport core (input tick, start, stop_idx, comp, output trial, result, busy, done);
  modport ctrl (output tick, start, stop_idx, comp, input trial, result, busy, done);
endinterface

// File: src/sac_pkg.sv
// Constants of the converter control block: register map, fields, states.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
//
// Operation
// - Mode bits 1:0 pick 10, 12, 8 bits.
// - Mode bit 3 low adds two calibration cycles.
// - Mode bit 2 low powers down after conversion.
// - Eight-bit result in 11:4, low bits zero.
// - Ten-bit result in 11:2, low bits zero.
// - Converter period is four times divider plus one.
// - Converter clock stays internal, never exported.
// - Inputs sampled on system clock; start on edge; here the start pin is taken as a level while idle.
// - Comparator sleep powers down only the comparators.
// - Reference select 0 drives internal reference out.
// - 32-way input mux; channel 31 is temperature.
// - Sample-time control sets the acquisition length.
// - Twelve-bit mode sustains up to 500 ksps.
package sac_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int RES_W  = 12;
  localparam int ADR_W  = 8;
  localparam int CHAN_W = 5;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [ADR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADR_W-1:0] ADDR_START  = 8'h04;
  localparam logic [ADR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [ADR_W-1:0] ADDR_RESULT = 8'h0c;

  localparam int CTRL_RES_LSB  = 0;
  localparam int CTRL_STAY     = 2;
  localparam int CTRL_NOCAL    = 3;
  localparam int CTRL_DIV_LSB  = 4;
  localparam int CTRL_STC_LSB  = 12;
  localparam int CTRL_REF      = 20;
  localparam int CTRL_SLEEP    = 21;
  localparam int CTRL_CHAN_LSB = 22;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0010;
  localparam logic [31:0] CTRL_MASK = 32'h07ff_ffff;

  localparam int START_BIT   = 0;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_VALID  = 1;
  localparam int STAT_POWER  = 2;
  localparam int STAT_SAMPLE = 3;

  // ------------------------------------------------------------
  // Modes and timing
  // ------------------------------------------------------------
  localparam logic [1:0] RES_10 = 2'h0;
  localparam logic [1:0] RES_12 = 2'h1;
  localparam logic [1:0] RES_8  = 2'h2;
  localparam logic [3:0] STOP_8  = 4'h4;
  localparam logic [3:0] STOP_10 = 4'h2;
  localparam logic [3:0] STOP_12 = 4'h0;
  localparam logic [RES_W-1:0] TRIAL_INIT = 12'h800;
  localparam logic [7:0] CAL_TICKS = 8'h02;
  localparam int DIV_MULT = 4;
  localparam logic [CHAN_W-1:0] TEMP_CHANNEL = 5'h1f;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACQ  = 2'b01,
    ST_CONV = 2'b10,
    ST_CAL  = 2'b11
  } sac_state_t;

endpackage

// File: src/sac_sar.sv
// Successive-approximation register: one trial bit per converter tick.
// Assumes the comparator answer for the current trial is settled at the tick.
`timescale 1ns/10ps

module sac_sar
  import sac_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  sac_conv_if.core  cv
);
  logic [RES_W-1:0] code;
  logic [RES_W-1:0] keep;
  logic [3:0]       idx;

  assign keep = cv.comp ? cv.trial : code;

  // Bits below the stop index are never tried, so they stay zero.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      code      <= '0;
      idx       <= 4'h0;
      cv.trial  <= '0;
      cv.result <= '0;
      cv.busy   <= 1'b0;
      cv.done   <= 1'b0;
    end
    else
    begin
      cv.done <= 1'b0;
      if (cv.start)
      begin
        code     <= '0;
        idx      <= 4'(RES_W - 1);
        cv.trial <= TRIAL_INIT;
        cv.busy  <= 1'b1;
      end
      else if (cv.busy && cv.tick)
      begin
        if (idx == cv.stop_idx)
        begin
          cv.result <= keep;
          cv.trial  <= keep;
          cv.busy   <= 1'b0;
          cv.done   <= 1'b1;
        end
        else
        begin
          code     <= keep;
          idx      <= idx - 4'h1;
          cv.trial <= keep | (12'h001 << (idx - 4'h1));
        end
      end
    end
  end
endmodule

// File: src/sac_top.sv
// Top of the converter control block: Wishbone slave, sequencer,
// comparator synchroniser and the checks on them.
// Assumes an analog front end outside that compares the held input with
// trial_code_o and answers on the asynchronous comparator_i pin.
`timescale 1ns/10ps

module sac_top
  import sac_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              conversion_start_i,
  input  wire logic              comparator_i,
  output logic      [RES_W-1:0]  trial_code_o,
  output logic                   sample_o,
  output logic      [CHAN_W-1:0] channel_o,
  output logic                   conv_power_o,
  output logic                   comparator_sleep_o,
  output logic                   reference_pin_drive_o,
  output logic      [RES_W-1:0]  result_o,
  output logic                   done_o
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  sac_conv_if cv ();

  logic [7:0]       ctrl_b [4];
  logic [31:0]      ctrl;
  logic [31:0]      rd_word;
  logic [31:0]      status_word;
  logic             bus_req;
  logic             bus_take;
  logic             ctrl_wr;
  logic             sw_start;
  logic             comp_meta;
  logic             comp_sync;
  sac_state_t       state;
  sac_state_t       next_state;
  logic             tick;
  logic [7:0]       tick_cnt;
  logic [1:0]       run_res;
  logic             run_stay;
  logic             run_nocal;
  logic [7:0]       run_div;
  logic [7:0]       run_stc;
  logic [3:0]       run_stop;
  logic             conv_start;
  logic             valid;
  logic             start_take;
  logic             acq_last;
  logic             conv_end;
  logic             cal_last;
  logic             finish;

  // ------------------------------------------------------------
  // Control fields
  // ------------------------------------------------------------
  assign ctrl = {ctrl_b[3], ctrl_b[2], ctrl_b[1], ctrl_b[0]};

  function automatic logic [3:0] stop_of(input logic [1:0] res);
    case (res)
      RES_8:   stop_of = STOP_8;
      RES_12:  stop_of = STOP_12;
      default: stop_of = STOP_10;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Wishbone slave
  // ------------------------------------------------------------
  assign bus_req  = wb_cyc_i && wb_stb_i;
  assign bus_take = bus_req && wb_ack_o;
  assign ctrl_wr  = bus_take && wb_we_i && (wb_adr_i == ADDR_CTRL);

  // Every access, mapped or not, is answered one cycle after it is seen.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= bus_req && !wb_ack_o;
    end
  end

  always_comb
  begin
    status_word              = '0;
    status_word[STAT_BUSY]   = (state != ST_IDLE);
    status_word[STAT_VALID]  = valid;
    status_word[STAT_POWER]  = conv_power_o;
    status_word[STAT_SAMPLE] = sample_o;
  end

  always_comb
  begin
    case (wb_adr_i)
      ADDR_CTRL:   rd_word = ctrl & CTRL_MASK;
      ADDR_STATUS: rd_word = status_word;
      ADDR_RESULT: rd_word = {20'h0_0000, result_o};
      default:     rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (bus_req && !wb_ack_o)
    begin
      wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_word;
    end
  end

  // Byte lanes of the control word are written independently.
  for (genvar b = 0; b < 4; b++)
  begin : g_lane
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        ctrl_b[b] <= CTRL_RST[8*b +: 8];
      end
      else if (ctrl_wr && wb_sel_i[b])
      begin
        ctrl_b[b] <= wb_dat_i[8*b +: 8] & CTRL_MASK[8*b +: 8];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sw_start <= 1'b0;
    end
    else
    begin
      sw_start <= bus_take && wb_we_i && (wb_adr_i == ADDR_START)
                  && wb_sel_i[0] && wb_dat_i[START_BIT];
    end
  end

  // ------------------------------------------------------------
  // Comparator synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end
    else
    begin
      comp_meta <= comparator_i;
      comp_sync <= comp_meta;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // A start while a conversion runs is dropped, never queued.
  assign start_take = (state == ST_IDLE) && (conversion_start_i || sw_start);
  assign acq_last   = (state == ST_ACQ) && tick && (tick_cnt == run_stc);
  assign conv_end   = (state == ST_CONV) && cv.done;
  assign cal_last   = (state == ST_CAL) && tick && (tick_cnt == CAL_TICKS - 8'h01);
  assign finish     = (conv_end && run_nocal) || cal_last;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE: if (start_take) next_state = ST_ACQ;
      ST_ACQ:  if (acq_last) next_state = ST_CONV;
      ST_CONV: if (conv_end) next_state = run_nocal ? ST_IDLE : ST_CAL;
      ST_CAL:  if (cal_last) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || start_take || acq_last || conv_end)
    begin
      tick_cnt <= 8'h00;
    end
    else if (tick && (state == ST_ACQ || state == ST_CAL))
    begin
      tick_cnt <= tick_cnt + 8'h01;
    end
  end

  // Settings other than comparator sleep and reference select are frozen at start so a write to them mid-conversion cannot tear it.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_res   <= RES_10;
      run_stay  <= 1'b0;
      run_nocal <= 1'b0;
      run_div   <= 8'h00;
      run_stc   <= 8'h00;
      run_stop  <= STOP_10;
      channel_o <= '0;
    end
    else if (start_take)
    begin
      run_res   <= ctrl[CTRL_RES_LSB +: 2];
      run_stay  <= ctrl[CTRL_STAY];
      run_nocal <= ctrl[CTRL_NOCAL];
      run_div   <= ctrl[CTRL_DIV_LSB +: 8];
      run_stc   <= ctrl[CTRL_STC_LSB +: 8];
      run_stop  <= stop_of(ctrl[CTRL_RES_LSB +: 2]);
      channel_o <= ctrl[CTRL_CHAN_LSB +: CHAN_W];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      conv_start <= 1'b0;
      sample_o   <= 1'b0;
    end
    else
    begin
      conv_start <= acq_last;
      sample_o   <= (next_state == ST_ACQ);
    end
  end

  // ------------------------------------------------------------
  // Outputs and status
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      result_o <= '0;
      done_o   <= 1'b0;
    end
    else
    begin
      done_o <= finish;
      if (conv_end)
      begin
        result_o <= cv.result;
      end
    end
  end

  // Powering up happens at start; the analog side must settle during sampling.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      conv_power_o <= 1'b0;
    end
    else if (start_take)
    begin
      conv_power_o <= 1'b1;
    end
    else if (finish && !run_stay)
    begin
      conv_power_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      comparator_sleep_o    <= 1'b0;
      reference_pin_drive_o <= 1'b1;
      trial_code_o          <= '0;
    end
    else
    begin
      comparator_sleep_o    <= ctrl[CTRL_SLEEP];
      reference_pin_drive_o <= !ctrl[CTRL_REF];
      trial_code_o          <= cv.trial;
    end
  end

  // A finishing conversion always outranks the clear by a new start.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      valid <= 1'b0;
    end
    else if (finish)
    begin
      valid <= 1'b1;
    end
    else if (start_take)
    begin
      valid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Converter clock and bit engine
  // ------------------------------------------------------------
  // With divider 0 the trial-to-tick window is four cycles, enough for the
  // output flop and the two synchroniser stages only if the comparator is fast.
  sac_clkdiv u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (state != ST_IDLE),
    .div_i  (run_div),
    .tick_o (tick)
  );

  assign cv.tick     = tick;
  // The engine loads at the last acquisition tick, so the first trial also
  // gets a full converter period to pass the output flop and synchroniser.
  assign cv.start    = acq_last;
  assign cv.stop_idx = run_stop;
  assign cv.comp     = comp_sync;

  sac_sar u_sar (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cv    (cv)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [9:0] gap;
  logic [3:0] conv_ticks;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || state == ST_IDLE)
    begin
      gap <= 10'h000;
    end
    else if (tick)
    begin
      gap <= 10'h001;
    end
    else
    begin
      gap <= gap + 10'h001;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || conv_start)
    begin
      conv_ticks <= 4'h0;
    end
    else if (tick && state == ST_CONV)
    begin
      conv_ticks <= conv_ticks + 4'h1;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_start_taken;
    state == ST_IDLE && (conversion_start_i || sw_start);
  endsequence

  sequence s_acq_done;
    state == ST_ACQ && tick && tick_cnt == run_stc;
  endsequence

  a_conv_bits: assert property (cv.done |-> conv_ticks == 4'(RES_W) - run_stop)
    else $error("conversion tick count does not match resolution");
  a_cal_two: assert property (conv_end && !run_nocal |=> state == ST_CAL ##1 !done_o[*2])
    else $error("calibration phase missing or too short");
  a_power_off: assert property (done_o && !run_stay |-> !conv_power_o)
    else $error("converter still powered after conversion");
  a_eight_low: assert property (done_o && run_res == RES_8 |-> result_o[3:0] == 4'h0)
    else $error("eight-bit result low bits not zero");
  a_ten_low: assert property (done_o && run_res == RES_10 |-> result_o[1:0] == 2'h0)
    else $error("ten-bit result low bits not zero");
  a_div_period: assert property (tick |-> gap == 10'(DIV_MULT * (int'(run_div) + 1)))
    else $error("converter tick spacing wrong");
  a_start_taken: assert property (s_start_taken |=> state == ST_ACQ && sample_o)
    else $error("start not taken");
  a_sleep_follow: assert property ($rose(ctrl[CTRL_SLEEP]) |=> comparator_sleep_o)
    else $error("comparator sleep not applied");
  a_ref_drive: assert property (!ctrl[CTRL_REF] |=> reference_pin_drive_o)
    else $error("internal reference not driven");
  a_acq_length: assert property (s_acq_done |=> state == ST_CONV && !sample_o)
    else $error("acquisition phase length wrong");
  a_done_pulse: assert property (done_o |=> !done_o && state == ST_IDLE)
    else $error("done is not a single pulse");

endmodule

// File: tb/sac_afe_model.sv
// Analog front end model: compares a held input level with the trial code.
// Assumes trial_code_i is a register on clk_i and vin_i is held per conversion.
`timescale 1ns/10ps

module sac_afe_model
  import sac_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic [RES_W-1:0] trial_code_i,
  input  wire logic [RES_W-1:0] vin_i,
  input  wire logic             power_i,
  input  wire logic             sleep_i,
  output logic                  comparator_o
);
  // ------------------------------------------------------------
  // Comparator
  // ------------------------------------------------------------
  // A sleeping or unpowered comparator gives no answer, so it toggles.
  // That way a design which converts while asleep cannot pass by luck.
  logic toggle = 1'b0;

  always @(posedge clk_i)
  begin
    toggle <= ~toggle;
  end

  // A fast comparator settles in the same cycle as the trial code.
  assign comparator_o = (power_i && !sleep_i) ? (vin_i >= trial_code_i) : toggle;
endmodule

// File: tb/sac_top_tb_top.sv
// Self-checking bench of the converter control block over Wishbone.
// Assumes the front end model answers in the same cycle as the trial code.
`timescale 1ns/10ps

module sac_top_tb_top
  import sac_pkg::*;
();
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              wb_cyc_i = 1'b0;
  logic              wb_stb_i = 1'b0;
  logic              wb_we_i = 1'b0;
  logic [ADR_W-1:0]  wb_adr_i = 8'h00;
  logic [3:0]        wb_sel_i = 4'h0;
  logic [31:0]       wb_dat_i = 32'h0;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  logic              conversion_start_i = 1'b0;
  logic              comparator_i;
  logic [RES_W-1:0]  trial_code_o;
  logic              sample_o;
  logic [CHAN_W-1:0] channel_o;
  logic              conv_power_o;
  logic              comparator_sleep_o;
  logic              reference_pin_drive_o;
  logic [RES_W-1:0]  result_o;
  logic              done_o;
  logic [RES_W-1:0]  vin = 12'h000;
  logic [31:0]       rd;
  int                error_cnt = 0;
  int                compares = 0;

  sac_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conversion_start_i(conversion_start_i),
    .comparator_i(comparator_i), .trial_code_o(trial_code_o), .sample_o(sample_o),
    .channel_o(channel_o), .conv_power_o(conv_power_o),
    .comparator_sleep_o(comparator_sleep_o), .reference_pin_drive_o(reference_pin_drive_o),
    .result_o(result_o), .done_o(done_o));

  sac_afe_model i_afe (.clk_i(clk_i), .trial_code_i(trial_code_o), .vin_i(vin),
    .power_i(conv_power_o), .sleep_i(comparator_sleep_o), .comparator_o(comparator_i));

  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic summarize();
    $display("Counts: compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The request is held until ack is sampled high; data is taken at that edge.
  task automatic wb_cycle(input logic we, input logic [ADR_W-1:0] adr,
                          input logic [31:0] dat, output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 100);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      error_cnt++;
      summarize();
    end
  endtask

  task automatic wb_wr(input logic [ADR_W-1:0] adr, input logic [31:0] dat);
    logic [31:0] dummy;
    wb_cycle(1'b1, adr, dat, dummy);
  endtask

  task automatic wait_done(output int cyc);
    cyc = 0;
    do
    begin
      @(posedge clk_i);
      cyc++;
    end
    while (done_o !== 1'b1 && cyc < 20000);
    if (done_o !== 1'b1)
    begin
      error_cnt++;
      summarize();
    end
  endtask

  // One conversion: program, start by bus or pin, then check timing and result.
  task automatic run_conv(input logic [1:0] res, input logic stay, input logic nocal,
                          input logic [7:0] div, input logic [7:0] sample_time_ctrl,
                          input logic [4:0] chan, input logic ref_sel,
                          input logic pin, input logic [11:0] v);
    logic [31:0] ctrl;
    logic [11:0] exp;
    int          cyc;
    int          p;
    int          n;
    int          lo;
    ctrl = {5'h00, chan, 1'b0, ref_sel, sample_time_ctrl, div, nocal, stay, res};
    vin <= v;
    wb_wr(ADDR_CTRL, ctrl);
    wb_cycle(1'b0, ADDR_CTRL, 32'h0, rd);
    check(rd, ctrl);
    check(32'(reference_pin_drive_o), 32'(!ref_sel));
    if (pin)
    begin
      @(posedge clk_i);
      conversion_start_i <= 1'b1;
      @(posedge clk_i);
      conversion_start_i <= 1'b0;
      @(posedge clk_i);
      check(32'(sample_o), 32'h1);
    end
    else
    begin
      wb_wr(ADDR_START, 32'h1);
    end
    p = 4 * (1 + int'(div));
    n = (res == RES_12) ? 12 : ((res == RES_8) ? 8 : 10);
    lo = (int'(sample_time_ctrl) + 1) * p + n * p + (nocal ? 0 : 2 * p);
    exp = (n == 12) ? v : ((n == 8) ? {v[11:4], 4'h0} : {v[11:2], 2'h0});
    wait_done(cyc);
    check(32'(cyc >= lo && cyc <= lo + 12), 32'h1);
    check(32'(result_o), 32'(exp));
    check(32'(channel_o), 32'(chan));
    @(posedge clk_i);
    check(32'(done_o), 32'h0);
    @(posedge clk_i);
    check(32'(conv_power_o), 32'(stay));
    wb_cycle(1'b0, ADDR_RESULT, 32'h0, rd);
    check(rd, 32'(exp));
    wb_cycle(1'b0, ADDR_STATUS, 32'h0, rd);
    check(rd, 32'h2 | (32'(stay) << STAT_POWER));
    $display("Test conversion res=%h div=%h stc=%h done in %0d cycles", res, div, sample_time_ctrl, cyc);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  // Dividers 0 and 1 give 5 and 2.5 MHz, inside the legal band.
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(32'(reference_pin_drive_o), 32'h1);
    wb_cycle(1'b0, ADDR_CTRL, 32'h0, rd);
    check(rd, CTRL_RST);
    wb_cycle(1'b0, ADDR_STATUS, 32'h0, rd);
    check(rd, 32'h0);
    wb_wr(8'h10, 32'hffff_ffff);
    wb_cycle(1'b0, 8'h10, 32'h0, rd);
    check(rd, 32'h0);
    wb_cycle(1'b0, ADDR_CTRL, 32'h0, rd);
    check(rd, CTRL_RST);
    $display("Test reset and unmapped access done");
    run_conv(RES_8, 1'b0, 1'b0, 8'h00, 8'h00, 5'h10, 1'b0, 1'b0, 12'ha5c);
    run_conv(RES_10, 1'b1, 1'b1, 8'h01, 8'h02, 5'h1e, 1'b1, 1'b1, 12'h3ff);
    run_conv(RES_12, 1'b1, 1'b0, 8'h00, 8'h01, TEMP_CHANNEL, 1'b0, 1'b0, 12'hfff);
    run_conv(RES_12, 1'b0, 1'b1, 8'h01, 8'h00, 5'h00, 1'b1, 1'b1, 12'h801);
    wb_wr(ADDR_CTRL, 32'h0030_0000);
    repeat (3) @(posedge clk_i);
    check(32'(comparator_sleep_o), 32'h1);
    check(32'(conv_power_o), 32'h0);
    check(32'(reference_pin_drive_o), 32'h0);
    wb_wr(ADDR_CTRL, CTRL_RST);
    repeat (3) @(posedge clk_i);
    check(32'(comparator_sleep_o), 32'h0);
    $display("Test comparator sleep done");
    summarize();
  end
endmodule
